// [hw/scp_blk_meta.sv]
// Per-block time stamp, format and parity fault capture
`timescale 1ns/1ps
module scp_blk_meta
  import scp_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  reset_n,
  input  wire logic                  rx_start,
  input  wire logic [REL_TIME_W-1:0] rel_time,
  input  wire logic [STAMP_W-1:0]    sec_time,
  input  wire logic [FMT_W-1:0]      sec_time_fmt,
  input  wire logic                  sec_en,
  input  wire logic                  take,
  input  wire logic                  take_first,
  input  wire logic                  rx_parity_err,
  input  wire logic                  close,
  output logic      [STAMP_W-1:0]    blk_stamp,
  output logic      [FMT_W-1:0]      blk_fmt,
  output logic                       blk_pe
);

  logic [STAMP_W-1:0] pend_stamp_r;
  logic [FMT_W-1:0]   pend_fmt_r;
  logic [STAMP_W-1:0] cur_stamp_r;
  logic [FMT_W-1:0]   cur_fmt_r;
  logic               cur_pe_r;

  // Time source chosen at each start bit
  wire [STAMP_W-1:0] time_sel = sec_en ? sec_time : {TIME_ZERO, rel_time};
  wire [FMT_W-1:0]   fmt_sel  = sec_en ? sec_time_fmt : '0;
  wire               pe_nxt   = take_first ? rx_parity_err : (cur_pe_r | (take & rx_parity_err));

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pend_stamp_r <= '0;
      pend_fmt_r   <= '0;
    end else if (rx_start) begin
      pend_stamp_r <= time_sel;
      pend_fmt_r   <= fmt_sel;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cur_stamp_r <= '0;
      cur_fmt_r   <= '0;
      cur_pe_r    <= 1'b0;
    end else begin
      cur_pe_r <= pe_nxt;
      if (take_first) begin
        cur_stamp_r <= pend_stamp_r;
        cur_fmt_r   <= pend_fmt_r;
      end
    end
  end

  // Frozen copy for the block being emitted
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      blk_stamp <= '0;
      blk_fmt   <= '0;
      blk_pe    <= 1'b0;
    end else if (close) begin
      blk_stamp <= cur_stamp_r;
      blk_fmt   <= cur_fmt_r;
      blk_pe    <= cur_pe_r;
    end
  end

endmodule

// [hw/scp_packetizer.sv]
// Serial channel packetizer top: block collection, packet emission, registers
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module scp_packetizer
  import scp_pkg::*;
#(
  parameter int BLK_DEPTH = 256
) (
  input  wire logic                  clk_sys,
  input  wire logic                  reset_n,
  input  wire logic [ADDR_W-1:0]     reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [31:0]           reg_rdata,
  input  wire logic                  rx_valid,
  input  wire logic [7:0]            rx_byte,
  input  wire logic [SUB_W-1:0]      rx_sub,
  input  wire logic                  rx_parity_err,
  input  wire logic                  rx_start,
  output logic                       rx_ack,
  input  wire logic [REL_TIME_W-1:0] rel_time,
  input  wire logic [STAMP_W-1:0]    sec_time,
  input  wire logic [FMT_W-1:0]      sec_time_fmt,
  output logic                       out_valid,
  output logic      [15:0]           out_word,
  output logic                       out_sop,
  output logic                       out_eop,
  input  wire logic                  out_ready,
  output logic                       irq
);

  localparam int AW = $clog2(BLK_DEPTH);

  scp_state_t         st_r;
  scp_state_t         st_nxt;
  logic [7:0]         mem [BLK_DEPTH];
  logic [CNT_W-1:0]   coll_cnt_r;
  logic [CNT_W-1:0]   out_cnt_r;
  logic [CNT_W-1:0]   idx_r;
  logic [SUB_W-1:0]   cur_sub_r;
  logic [SUB_W-1:0]   out_sub_r;
  logic               end_blk_r;
  logic               pkt_open_r;
  logic               pkt_ts_r;
  logic               flush_pend_r;
  logic [CTRL_W-1:0]  ctrl_r;
  logic [INT_W-1:0]   int_stat_r;
  logic [INT_W-1:0]   int_mask_r;
  logic [STAMP_W-1:0] blk_stamp;
  logic [FMT_W-1:0]   blk_fmt;
  logic               blk_pe;
  logic [15:0]        word_nxt;
  logic               last_nxt;
  logic [INT_W-1:0]   int_ev;
  logic [31:0]        status_w;

  // Low or high half of a 32-bit header field
  function automatic logic [15:0] half_sel(input logic hi, input logic [31:0] w);
    half_sel = hi ? w[31:16] : w[15:0];
  endfunction

  // Register offset match
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a, input logic [7:0] offs);
    reg_hit = (a == offs);
  endfunction

  // Collection side
  wire collecting = (st_r == S_COLLECT);
  wire blk_open   = (coll_cnt_r != '0);
  wire blk_full   = (coll_cnt_r == CNT_W'(BLK_DEPTH));
  wire rx_pend    = rx_valid && !rx_ack;
  wire sub_chg    = rx_pend && (rx_sub != cur_sub_r);
  wire close      = collecting && blk_open && (sub_chg || blk_full || flush_pend_r);
  wire take       = collecting && rx_pend && !close;
  wire take_first = take && !blk_open;

  // Emission side
  wire               adv      = !out_valid || out_ready;
  wire               emitting = !collecting && adv;
  wire [CNT_W-1:0]   last_w   = (out_cnt_r - 16'd1) >> 1;
  wire [CNT_W:0]     hi_pos   = {idx_r, 1'b1};
  wire [AW-1:0]      lo_addr  = AW'({idx_r, 1'b0});
  wire [AW-1:0]      hi_addr  = AW'(hi_pos);
  wire               hi_real  = hi_pos < {1'b0, out_cnt_r};
  wire [7:0]         hi_byte  = hi_real ? mem[hi_addr] : FILL_BYTE;
  wire [31:0]        desc     = {pkt_ts_r, 31'h0};
  wire [31:0]        id_word  = {blk_pe, 1'b0, out_sub_r, out_cnt_r};
  wire [15:0]        ts_half  = blk_stamp[{idx_r[1:0], 4'h0} +: 16];
  wire               data_end = emitting && (st_r == S_DATA) && last_nxt;
  wire               pkt_end  = data_end && end_blk_r;

  // Word select per state
  always_comb begin
    word_nxt = '0;
    last_nxt = 1'b0;
    unique case (st_r)
      S_COLLECT: begin
        word_nxt = '0;
      end
      S_DESC: begin
        word_nxt = half_sel(idx_r[0], desc);
        last_nxt = (idx_r == CNT_W'(HDR_LAST_IDX));
      end
      S_TS: begin
        word_nxt = ts_half;
        last_nxt = (idx_r == CNT_W'(TS_LAST_IDX));
      end
      S_ID: begin
        word_nxt = half_sel(idx_r[0], id_word);
        last_nxt = (idx_r == CNT_W'(HDR_LAST_IDX));
      end
      S_DATA: begin
        word_nxt = {hi_byte, mem[lo_addr]};
        last_nxt = (idx_r == last_w);
      end
    endcase
  end

  // Next state
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      S_COLLECT: begin
        if (close) begin
          st_nxt = !pkt_open_r ? S_DESC : (pkt_ts_r ? S_TS : S_ID);
        end
      end
      S_DESC: begin
        if (emitting && last_nxt) begin
          st_nxt = pkt_ts_r ? S_TS : S_ID;
        end
      end
      S_TS: begin
        if (emitting && last_nxt) begin
          st_nxt = S_ID;
        end
      end
      S_ID: begin
        if (emitting && last_nxt) begin
          st_nxt = S_DATA;
        end
      end
      S_DATA: begin
        if (emitting && last_nxt) begin
          st_nxt = S_COLLECT;
        end
      end
    endcase
  end

  // State and word index
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_r  <= S_COLLECT;
      idx_r <= '0;
    end else begin
      st_r <= st_nxt;
      if (st_nxt != st_r) begin
        idx_r <= '0;
      end else if (emitting) begin
        idx_r <= idx_r + 16'd1;
      end
    end
  end

  // Byte store of the open block
  always_ff @(posedge clk_sys) begin
    if (take) begin
      mem[AW'(coll_cnt_r)] <= rx_byte;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      coll_cnt_r <= '0;
      cur_sub_r  <= '0;
      rx_ack     <= 1'b0;
    end else begin
      rx_ack <= take;
      if (close) begin
        coll_cnt_r <= '0;
      end else if (take) begin
        coll_cnt_r <= coll_cnt_r + 16'd1;
      end
      if (take_first) begin
        cur_sub_r <= rx_sub;
      end
    end
  end

  // Snapshot of the closed block and packet framing
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      out_cnt_r  <= '0;
      out_sub_r  <= '0;
      end_blk_r  <= 1'b0;
      pkt_open_r <= 1'b0;
      pkt_ts_r   <= 1'b0;
    end else begin
      if (close) begin
        out_cnt_r <= coll_cnt_r;
        out_sub_r <= cur_sub_r;
        end_blk_r <= flush_pend_r;
      end
      if (close && !pkt_open_r) begin
        pkt_open_r <= 1'b1;
        pkt_ts_r   <= ctrl_r[CTRL_TS_BIT];
      end else if (pkt_end) begin
        pkt_open_r <= 1'b0;
      end
    end
  end

  scp_blk_meta u_meta (
    .clk_sys       (clk_sys),
    .reset_n       (reset_n),
    .rx_start      (rx_start),
    .rel_time      (rel_time),
    .sec_time      (sec_time),
    .sec_time_fmt  (sec_time_fmt),
    .sec_en        (ctrl_r[CTRL_SEC_BIT]),
    .take          (take),
    .take_first    (take_first),
    .rx_parity_err (rx_parity_err),
    .close         (close),
    .blk_stamp     (blk_stamp),
    .blk_fmt       (blk_fmt),
    .blk_pe        (blk_pe)
  );

  // Output word stage
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      out_valid <= 1'b0;
      out_word  <= '0;
      out_sop   <= 1'b0;
      out_eop   <= 1'b0;
    end else if (adv) begin
      out_valid <= !collecting;
      out_word  <= word_nxt;
      out_sop   <= (st_r == S_DESC) && (idx_r == '0);
      out_eop   <= pkt_end;
    end
  end

  // Register access
  wire wr_ctrl  = reg_wr && reg_hit(reg_addr, REG_CTRL);
  wire wr_cmd   = reg_wr && reg_hit(reg_addr, REG_CMD);
  wire wr_istat = reg_wr && reg_hit(reg_addr, REG_INT_STAT);
  wire wr_imask = reg_wr && reg_hit(reg_addr, REG_INT_MASK);

  // Event strobes into the sticky status
  always_comb begin
    int_ev          = '0;
    int_ev[INT_BLK] = data_end;
    int_ev[INT_END] = pkt_end;
    int_ev[INT_PAR] = data_end && blk_pe;
  end

  wire [INT_W-1:0] int_clr   = wr_istat ? reg_wdata[INT_W-1:0] : '0;
  wire             flush_set = wr_cmd && reg_wdata[CMD_END_BIT];
  wire             flush_clr = pkt_end || (collecting && !blk_open && !pkt_open_r);

  // Status word from its fields
  always_comb begin
    status_w                      = '0;
    status_w[ST_OPEN_BIT]         = pkt_open_r;
    status_w[ST_BUSY_BIT]         = !collecting;
    status_w[ST_END_BIT]          = flush_pend_r;
    status_w[ST_FMT_LSB +: FMT_W] = blk_fmt;
    status_w[ST_CNT_LSB +: CNT_W] = coll_cnt_r;
  end

  wire [31:0] rd_val =
      reg_hit(reg_addr, REG_CTRL)     ? {{(32 - CTRL_W){1'b0}}, ctrl_r} :
      reg_hit(reg_addr, REG_STATUS)   ? status_w :
      reg_hit(reg_addr, REG_INT_STAT) ? {{(32 - INT_W){1'b0}}, int_stat_r} :
      reg_hit(reg_addr, REG_INT_MASK) ? {{(32 - INT_W){1'b0}}, int_mask_r} :
      32'h0000_0000;

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r       <= CTRL_RST;
      int_mask_r   <= INT_RST;
      int_stat_r   <= INT_RST;
      flush_pend_r <= 1'b0;
      reg_rdata    <= '0;
      irq          <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= reg_wdata[CTRL_W-1:0];
      end
      if (wr_imask) begin
        int_mask_r <= reg_wdata[INT_W-1:0];
      end
      int_stat_r   <= int_ev | (int_stat_r & ~int_clr);
      flush_pend_r <= flush_set | (flush_pend_r & !flush_clr);
      reg_rdata    <= reg_rd ? rd_val : '0;
      irq          <= |(int_stat_r & int_mask_r);
    end
  end

endmodule

// [hw/scp_pkg.sv]
// Constants, register map and state type for the serial channel packetizer
package scp_pkg;

  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_CMD      = 8'h04;
  localparam logic [7:0]  REG_STATUS   = 8'h08;
  localparam logic [7:0]  REG_INT_STAT = 8'h0c;
  localparam logic [7:0]  REG_INT_MASK = 8'h10;

  localparam int          CTRL_TS_BIT  = 0;
  localparam int          CTRL_SEC_BIT = 1;
  localparam int          CTRL_W       = 2;
  localparam logic [1:0]  CTRL_RST     = 2'h0;
  localparam int          CMD_END_BIT  = 0;

  localparam int          INT_BLK      = 0;
  localparam int          INT_END      = 1;
  localparam int          INT_PAR      = 2;
  localparam int          INT_W        = 3;
  localparam logic [2:0]  INT_RST      = 3'h0;

  localparam int          ST_OPEN_BIT  = 0;
  localparam int          ST_BUSY_BIT  = 1;
  localparam int          ST_END_BIT   = 2;
  localparam int          ST_FMT_LSB   = 4;
  localparam int          ST_CNT_LSB   = 16;

  localparam int          SUB_W        = 14;
  localparam int          CNT_W        = 16;
  localparam int          REL_TIME_W   = 48;
  localparam int          STAMP_W      = 64;
  localparam int          FMT_W        = 2;
  localparam logic [7:0]  FILL_BYTE    = 8'h00;
  localparam logic [15:0] TIME_ZERO    = 16'h0000;
  localparam int          TS_LAST_IDX  = 3;
  localparam int          HDR_LAST_IDX = 1;

  typedef enum logic [2:0] {
    S_COLLECT,
    S_DESC,
    S_TS,
    S_ID,
    S_DATA
  } scp_state_t;

endpackage

// [verification/scp_chk.sv]
// Checker for the packetizer output stream and byte handshake
`timescale 1ns/1ps
module scp_chk (
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        rx_ack,
  input wire logic        out_valid,
  input wire logic [15:0] out_word,
  input wire logic        out_sop,
  input wire logic        out_eop,
  input wire logic        out_ready
);
  logic [15:0] pos_r;
  logic        ts_r;
  wire         acc    = out_valid && out_ready;
  wire  [15:0] id_pos = ts_r ? 16'h0006 : 16'h0002;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Word index within the packet
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pos_r <= 16'h0000;
      ts_r  <= 1'b0;
    end else if (acc) begin
      pos_r <= out_sop ? 16'h0001 : pos_r + 16'h0001;
      ts_r  <= (pos_r == 16'h0001) ? out_word[15] : ts_r;
    end
  end
  AST_DESC_LOW: assert property (out_valid && out_sop |-> out_word == 16'h0000)
    else $error("descriptor low half not zero");
  AST_DESC_HIGH: assert property (out_valid && !out_sop && pos_r == 16'h0001 |-> out_word[14:0] == 15'h0000)
    else $error("descriptor reserved bits set");
  AST_ID_COUNT: assert property (out_valid && !out_sop && pos_r == id_pos |-> out_word != 16'h0000)
    else $error("block byte count is zero");
  AST_ID_RSVD: assert property (out_valid && !out_sop && pos_r == id_pos + 16'h0001 |-> !out_word[14])
    else $error("identification bit 30 set");
  AST_HOLD: assert property (out_valid && !out_ready |=> out_valid && $stable(out_word) && $stable(out_eop))
    else $error("output word changed while stalled");
  AST_NO_TAKE: assert property (rx_ack && out_valid |->
    $past(out_valid) && !$past(out_ready) && $stable(out_word))
    else $error("byte taken during emission");
  AST_ACK_PULSE: assert property (rx_ack |=> !rx_ack)
    else $error("byte acknowledge longer than one cycle");
  AST_EOP_END: assert property (acc && out_eop |=> !out_valid)
    else $error("word presented right after packet end");
  cover property (acc && out_eop);
  cover property (out_valid && !out_ready);
  cover property (out_valid && ts_r && pos_r == 16'h0007);
endmodule

bind scp_packetizer scp_chk u_chk (.clk_sys(clk_sys), .reset_n(reset_n), .rx_ack(rx_ack), .out_valid(out_valid),
  .out_word(out_word), .out_sop(out_sop), .out_eop(out_eop), .out_ready(out_ready));

// [verification/scp_store_model.sv]
// Packet store model: takes output words, stalling on request
`timescale 1ns/1ps
module scp_store_model (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        stall,
  input  wire logic        out_valid,
  input  wire logic [15:0] out_word,
  input  wire logic        out_sop,
  input  wire logic        out_eop,
  output logic             out_ready
);
  logic [17:0] q[$];
  // Ready toggles every cycle while stalling
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      out_ready <= 1'b0;
    end else begin
      out_ready <= stall ? ~out_ready : 1'b1;
      if (out_valid && out_ready) q.push_back({out_sop, out_eop, out_word});
    end
  end
endmodule

// [verification/tb_top.sv]
// Self-checking bench for the serial channel packetizer
`timescale 1ns/1ps
module tb_top
  import scp_pkg::*;
;
  typedef struct packed {
    logic ts; logic sec; logic [1:0] fmt; logic pe;
    logic [13:0] sa; logic [7:0] na; logic [13:0] sb; logic [7:0] nb; logic [7:0] nw;
  } scp_row_t;
  localparam scp_row_t ROWS [5] = '{
    '{1'b0, 1'b1, 2'h1, 1'b0, 14'h0003, 8'h02, 14'h0000, 8'h00, 8'h05},
    '{1'b1, 1'b1, 2'h0, 1'b1, 14'h0000, 8'h01, 14'h0005, 8'h03, 8'h11},
    '{1'b1, 1'b1, 2'h2, 1'b0, 14'h3fff, 8'h03, 14'h0000, 8'h00, 8'h0a},
    '{1'b1, 1'b0, 2'h1, 1'b1, 14'h0007, 8'h04, 14'h0008, 8'h01, 8'h11},
    '{1'b0, 1'b1, 2'h3, 1'b0, 14'h0001, 8'h02, 14'h0002, 8'h02, 8'h08}};
  logic                  clk_sys, reset_n, reg_wr, reg_rd, rx_valid, rx_parity_err, rx_start, stall;
  logic [ADDR_W-1:0]     reg_addr;
  logic [31:0]           reg_wdata, rd_d;
  logic [7:0]            rx_byte;
  logic [SUB_W-1:0]      rx_sub;
  logic [REL_TIME_W-1:0] rel_time;
  logic [STAMP_W-1:0]    sec_time;
  logic [FMT_W-1:0]      sec_time_fmt;
  logic [31:0]           reg_rdata;
  logic [15:0]           out_word;
  logic                  rx_ack, out_valid, out_sop, out_eop, out_ready, irq;
  logic [17:0]           exp_q[$];
  int                    num_errors, checks;
  scp_packetizer #(.BLK_DEPTH(4)) dut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .rx_sub(rx_sub), .rx_parity_err(rx_parity_err), .rx_start(rx_start), .rx_ack(rx_ack),
    .rel_time(rel_time), .sec_time(sec_time), .sec_time_fmt(sec_time_fmt), .out_valid(out_valid),
    .out_word(out_word), .out_sop(out_sop), .out_eop(out_eop), .out_ready(out_ready), .irq(irq));
  scp_store_model u_store (.clk_sys(clk_sys), .reset_n(reset_n), .stall(stall), .out_valid(out_valid),
    .out_word(out_word), .out_sop(out_sop), .out_eop(out_eop), .out_ready(out_ready));
  task tally_and_finish();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    rd_d = reg_rdata;
  endtask
  task add32(input logic [31:0] v);
    exp_q.push_back({2'b00, v[15:0]});
    exp_q.push_back({2'b00, v[31:16]});
  endtask
  task send(input logic [SUB_W-1:0] s, input logic [7:0] b, input logic pe, input logic [47:0] t);
    int k;
    @(posedge clk_sys);
    rel_time <= t;
    sec_time <= {16'h5a00, t};
    rx_start <= 1'b1;
    @(posedge clk_sys);
    rx_start      <= 1'b0;
    rx_valid      <= 1'b1;
    rx_byte       <= b;
    rx_sub        <= s;
    rx_parity_err <= pe;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (rx_ack !== 1'b1 && k < 300);
    rx_valid <= 1'b0;
  endtask
  task blk(input scp_row_t w, input int r, input int b);
    logic [47:0]      t;
    logic [7:0]       v;
    logic [7:0]       n;
    logic [SUB_W-1:0] s;
    t = 48'h0a00_0000_0000 + 48'(r * 256 + b * 16);
    v = 8'h40 + 8'(r * 16 + b * 8);
    n = b ? w.nb : w.na;
    s = b ? w.sb : w.sa;
    if (w.ts) begin
      add32(t[31:0]);
      add32({w.sec ? 16'h5a00 : 16'h0000, t[47:32]});
    end
    add32({w.pe && b == 0, 1'b0, s, 8'h00, n});
    for (int i = 0; i < n; i += 2)
      exp_q.push_back({2'b00, (i + 1 < n) ? v + 8'(i + 1) : FILL_BYTE, v + 8'(i)});
    for (int i = 0; i < n; i++)
      send(s, v + 8'(i), w.pe && b == 0 && i == n - 1, t + 48'(i));
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    tally_and_finish();
  end
  initial begin
    {reset_n, reg_wr, reg_rd, rx_valid, rx_parity_err, rx_start, stall} = 7'h00;
    {reg_addr, reg_wdata, rx_byte, rx_sub, rel_time, sec_time, sec_time_fmt} = '0;
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    chk("reset outputs", 4'h0, {out_valid, rx_ack, irq, out_sop});
    rd(REG_CTRL);
    chk("ctrl reset", CTRL_RST, rd_d);
    rd(REG_INT_MASK);
    chk("mask reset", INT_RST, rd_d);
    $display("test reset done");
    for (int r = 0; r < 5; r++) begin
      stall        <= r[0];
      sec_time_fmt <= ROWS[r].fmt;
      wr(REG_CTRL, {30'h0, ROWS[r].sec, ROWS[r].ts});
      exp_q.delete();
      u_store.q.delete();
      add32({ROWS[r].ts, 31'h0});
      blk(ROWS[r], r, 0);
      if (ROWS[r].nb != 8'h00) blk(ROWS[r], r, 1);
      exp_q[0][17] = 1'b1;
      exp_q[exp_q.size() - 1][16] = 1'b1;
      wr(REG_CMD, 32'h1);
      for (int k = 0; k < 400 && u_store.q[$][16] !== 1'b1; k++) @(posedge clk_sys);
      chk("word count", ROWS[r].nw, u_store.q.size());
      for (int i = 0; i < exp_q.size(); i++) chk("word", exp_q[i], u_store.q[i]);
      rd(REG_STATUS);
      chk("format", ROWS[r].sec ? ROWS[r].fmt : 2'h0, rd_d[5:4]);
      $display("test row %0d done", r);
    end
    rd(REG_INT_STAT);
    chk("int status", 32'h7, rd_d);
    chk("irq masked", 1'b0, irq);
    wr(REG_INT_MASK, 32'h2);
    repeat (2) @(posedge clk_sys);
    chk("irq", 1'b1, irq);
    wr(REG_INT_STAT, 32'h7);
    rd(REG_INT_STAT);
    chk("int cleared", 32'h0, rd_d);
    chk("irq cleared", 1'b0, irq);
    rd(8'h20);
    chk("unmapped", 32'h0, rd_d);
    $display("test interrupts done");
    wr(REG_CMD, 32'h1);
    rd(REG_STATUS);
    chk("idle end request", 3'h0, rd_d[2:0]);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    chk("mid reset outputs", 2'h0, {out_valid, irq});
    rd(REG_CTRL);
    chk("ctrl after reset", CTRL_RST, rd_d);
    $display("test idle and mid reset done");
    tally_and_finish();
  end
endmodule
